// ---- common/timing_polarity_pkg.sv ----
// Shared constants and carrier types for the timing output polarity block
package timing_polarity_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_POLARITY = 8'h56;
    localparam logic [7:0] IDX_PULSE_START = 8'h57;
    localparam logic [7:0] IDX_PULSE_STOP = 8'h58;
    localparam int ADDR_W = 12;

    // Polarity register bit positions
    localparam int POL_AUDIO_FRAME = 9;
    localparam int POL_TEN_FIELD = 8;
    localparam int POL_DISPLAY_EN = 7;
    localparam int POL_RESERVED = 6;
    localparam int POL_FIELD_DIGITAL = 5;
    localparam int POL_FIELD_SYNC = 4;
    localparam int POL_VBLANK = 3;
    localparam int POL_VSYNC = 2;
    localparam int POL_HBLANK = 1;
    localparam int POL_HSYNC = 0;

    // Writable polarity bits: 9..7 and 5..0
    localparam logic [15:0] POL_WRITE_MASK = 16'h03BF;
    localparam logic [15:0] POL_RESET = 16'h0000;
    localparam logic [15:0] PULSE_START_RESET = 16'h0000;
    localparam logic [15:0] PULSE_STOP_RESET = 16'h0000;

    // Last field index of a ten-field sequence
    localparam logic [3:0] TEN_FIELD_LAST = 4'h9;

    // Raw timing from the generator core, default polarities
    typedef struct packed {
        logic hsync_n;
        logic hblank;
        logic vsync;
        logic vblank;
        logic field_sync_one;
        logic field_digital_one;
        logic line_start;
        logic field_start;
        logic audio_div_reset;
        logic [15:0] pixel_count;
    } raw_timing_t;

    // Polarity-adjusted timing towards downstream video logic
    typedef struct packed {
        logic hsync;
        logic hblank;
        logic vsync;
        logic vblank;
        logic field_sync;
        logic field_digital;
        logic display_enable;
        logic ten_field_marker;
        logic audio_frame_marker;
        logic custom_line_pulse;
    } timing_out_t;

endpackage

// ---- design/timing_output_polarity.sv ----
// Timing output polarity control with APB register access
//
// Overview of operation
// - Bit 9 inverts audio frame marker
// - Audio marker high through line one
// - No-audio variant: no marker, bit ignored
// - Bit 8 inverts ten-field marker
// - Ten-field marker high one line per sequence
// - Bit 7 inverts display enable
// - Display enable high while pixels shown
// - Bit 5 inverts digital field flag
// - Digital field flag high during field one
// - Bit 4 inverts field sync flag
// - Field sync flag high during field one
// - Bit 3 inverts vertical blanking
// - Vertical blanking low during active video
// - Bit 2 inverts vertical sync
// - Bit 1 inverts horizontal blanking
// - Horizontal blanking low during active samples
// - Bit 0 inverts horizontal sync
// - Horizontal sync active low by default
// - Start register sets pulse leading pixel
// - Stop register sets first pixel after pulse
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module timing_output_polarity #(
    parameter bit HAS_AUDIO = 1'b1
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timing_polarity_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire timing_polarity_pkg::raw_timing_t i_raw,
    output timing_polarity_pkg::timing_out_t o_timing
);

    localparam logic [timing_polarity_pkg::ADDR_W-1:0] ADDR_POL =
        {2'b00, timing_polarity_pkg::IDX_POLARITY, 2'b00};
    localparam logic [timing_polarity_pkg::ADDR_W-1:0] ADDR_START =
        {2'b00, timing_polarity_pkg::IDX_PULSE_START, 2'b00};
    localparam logic [timing_polarity_pkg::ADDR_W-1:0] ADDR_STOP =
        {2'b00, timing_polarity_pkg::IDX_PULSE_STOP, 2'b00};

    logic [15:0] polarity_reg;
    logic [15:0] pulse_start_reg;
    logic [15:0] pulse_stop_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic [3:0] field_count_reg;
    logic ten_field_reg;
    logic audio_frame_reg;
    logic hit_pol;
    logic hit_start;
    logic hit_stop;
    logic mapped;
    logic wr_en;
    logic seq_start;
    logic [15:0] eff_pol;
    timing_polarity_pkg::timing_out_t raw_out;

    // APB decode; zero wait states, error on unmapped access
    assign hit_pol = (paddr == ADDR_POL);
    assign hit_start = (paddr == ADDR_START);
    assign hit_stop = (paddr == ADDR_STOP);
    assign mapped = hit_pol | hit_start | hit_stop;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en = psel & penable & pwrite & mapped;
    assign prdata = prdata_reg;

    always_comb begin
        prdata_next = 32'h0000_0000;
        if (hit_pol) begin
            prdata_next[15:0] = polarity_reg;
        end else if (hit_start) begin
            prdata_next[15:0] = pulse_start_reg;
        end else if (hit_stop) begin
            prdata_next[15:0] = pulse_stop_reg;
        end
    end

    // Read data captured in setup so it is stable in access
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_reg <= prdata_next;
        end
    end

    // reserved bit masked
    // Reserved bits are never stored, so a careless write does no harm
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            polarity_reg <= timing_polarity_pkg::POL_RESET;
        end else if (wr_en & hit_pol) begin
            polarity_reg <= pwdata[15:0] &
                timing_polarity_pkg::POL_WRITE_MASK;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pulse_start_reg <= timing_polarity_pkg::PULSE_START_RESET;
        end else if (wr_en & hit_start) begin
            pulse_start_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pulse_stop_reg <= timing_polarity_pkg::PULSE_STOP_RESET;
        end else if (wr_en & hit_stop) begin
            pulse_stop_reg <= pwdata[15:0];
        end
    end

    // Field counter for the ten-field sequence
    assign seq_start = i_raw.field_start &
        (field_count_reg == timing_polarity_pkg::TEN_FIELD_LAST);

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            field_count_reg <= timing_polarity_pkg::TEN_FIELD_LAST;
        end else if (i_raw.field_start) begin
            if (field_count_reg == timing_polarity_pkg::TEN_FIELD_LAST) begin
                field_count_reg <= 4'h0;
            end else begin
                field_count_reg <= field_count_reg + 4'h1;
            end
        end
    end

    // one line per sequence
    // Field start is also a line start, so setting must win
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ten_field_reg <= 1'b0;
        end else if (seq_start) begin
            ten_field_reg <= 1'b1;
        end else if (i_raw.line_start) begin
            ten_field_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            audio_frame_reg <= 1'b0;
        end else if (HAS_AUDIO & i_raw.audio_div_reset) begin
            audio_frame_reg <= 1'b1;
        end else if (i_raw.line_start) begin
            audio_frame_reg <= 1'b0;
        end
    end

    // Default-polarity signals before inversion
    always_comb begin
        raw_out.hsync = i_raw.hsync_n;
        raw_out.hblank = i_raw.hblank;
        raw_out.vsync = i_raw.vsync;
        raw_out.vblank = i_raw.vblank;
        raw_out.field_sync = i_raw.field_sync_one;
        raw_out.field_digital = i_raw.field_digital_one;
        raw_out.display_enable = ~i_raw.hblank & ~i_raw.vblank;
        raw_out.ten_field_marker = ten_field_reg;
        raw_out.audio_frame_marker = audio_frame_reg;
        raw_out.custom_line_pulse =
            (i_raw.pixel_count >= pulse_start_reg) &
            (i_raw.pixel_count < pulse_stop_reg);
    end

    assign eff_pol = HAS_AUDIO ? polarity_reg :
        (polarity_reg & ~(16'h0001 << timing_polarity_pkg::POL_AUDIO_FRAME));

    always_comb begin
        o_timing = raw_out;
        o_timing.hsync = raw_out.hsync ^
            eff_pol[timing_polarity_pkg::POL_HSYNC];
        o_timing.hblank = raw_out.hblank ^
            eff_pol[timing_polarity_pkg::POL_HBLANK];
        o_timing.vsync = raw_out.vsync ^
            eff_pol[timing_polarity_pkg::POL_VSYNC];
        o_timing.vblank = raw_out.vblank ^
            eff_pol[timing_polarity_pkg::POL_VBLANK];
        o_timing.field_sync = raw_out.field_sync ^
            eff_pol[timing_polarity_pkg::POL_FIELD_SYNC];
        o_timing.field_digital = raw_out.field_digital ^
            eff_pol[timing_polarity_pkg::POL_FIELD_DIGITAL];
        o_timing.display_enable = raw_out.display_enable ^
            eff_pol[timing_polarity_pkg::POL_DISPLAY_EN];
        o_timing.ten_field_marker = raw_out.ten_field_marker ^
            eff_pol[timing_polarity_pkg::POL_TEN_FIELD];
        o_timing.audio_frame_marker = raw_out.audio_frame_marker ^
            eff_pol[timing_polarity_pkg::POL_AUDIO_FRAME];
        // No inversion control for the user pulse here
        o_timing.custom_line_pulse = raw_out.custom_line_pulse;
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    sequence s_pol_write;
        psel && penable && pwrite && hit_pol;
    endsequence

    sequence s_seq_line;
        seq_start ##1 !i_raw.line_start;
    endsequence

    chk_reserved_bit_zero: assert property (
        s_pol_write |=> !polarity_reg[timing_polarity_pkg::POL_RESERVED])
        else $error("reserved polarity bit stored");

    chk_hsync_invert: assert property (
        o_timing.hsync == (i_raw.hsync_n ^
            polarity_reg[timing_polarity_pkg::POL_HSYNC]))
        else $error("hsync polarity wrong");

    chk_de_default: assert property (
        !polarity_reg[timing_polarity_pkg::POL_DISPLAY_EN] |->
        o_timing.display_enable == (!i_raw.hblank && !i_raw.vblank))
        else $error("display enable wrong");

    chk_vblank_invert: assert property (
        o_timing.vblank == (i_raw.vblank ^
            polarity_reg[timing_polarity_pkg::POL_VBLANK]))
        else $error("vblank polarity wrong");

    chk_ten_field_set: assert property (
        s_seq_line |-> ten_field_reg)
        else $error("ten-field marker not held");

    chk_ten_field_clear: assert property (
        i_raw.line_start && !seq_start |=> !ten_field_reg)
        else $error("ten-field marker past one line");

    chk_audio_marker: assert property (
        HAS_AUDIO && i_raw.audio_div_reset |=> audio_frame_reg)
        else $error("audio marker not set");

    chk_no_audio: assert property (
        !HAS_AUDIO |-> !audio_frame_reg &&
        o_timing.audio_frame_marker == 1'b0)
        else $error("audio marker in no-audio variant");

    chk_start_write: assert property (
        psel && penable && pwrite && hit_start |=>
        pulse_start_reg == 16'($past(pwdata)))
        else $error("start register not updated");

    chk_user_pulse: assert property (
        i_raw.pixel_count >= pulse_stop_reg |-> !o_timing.custom_line_pulse)
        else $error("user pulse past stop pixel");

    // Polarity checks against raw inputs or marker registers, plus marker, register and pulse checks
    chk_audio_invert: assert property (
        HAS_AUDIO |-> o_timing.audio_frame_marker == (audio_frame_reg ^
            polarity_reg[timing_polarity_pkg::POL_AUDIO_FRAME]))
        else $error("audio marker polarity wrong");

    chk_audio_clear: assert property (
        i_raw.line_start && !i_raw.audio_div_reset |=> !audio_frame_reg)
        else $error("audio marker past line one");

    chk_ten_field_invert: assert property (
        o_timing.ten_field_marker == (ten_field_reg ^
            polarity_reg[timing_polarity_pkg::POL_TEN_FIELD]))
        else $error("ten-field marker polarity wrong");

    chk_de_invert: assert property (
        polarity_reg[timing_polarity_pkg::POL_DISPLAY_EN] |->
        o_timing.display_enable == (i_raw.hblank || i_raw.vblank))
        else $error("display enable inversion wrong");

    chk_fdig_invert: assert property (
        o_timing.field_digital == (i_raw.field_digital_one ^
            polarity_reg[timing_polarity_pkg::POL_FIELD_DIGITAL]))
        else $error("digital field polarity wrong");

    chk_fdig_default: assert property (
        !polarity_reg[timing_polarity_pkg::POL_FIELD_DIGITAL] |->
        o_timing.field_digital == i_raw.field_digital_one)
        else $error("digital field default wrong");

    chk_fsync_invert: assert property (
        o_timing.field_sync == (i_raw.field_sync_one ^
            polarity_reg[timing_polarity_pkg::POL_FIELD_SYNC]))
        else $error("field sync polarity wrong");

    chk_fsync_default: assert property (
        !polarity_reg[timing_polarity_pkg::POL_FIELD_SYNC] |->
        o_timing.field_sync == i_raw.field_sync_one)
        else $error("field sync default wrong");

    chk_vblank_default: assert property (
        !polarity_reg[timing_polarity_pkg::POL_VBLANK] |->
        o_timing.vblank == i_raw.vblank)
        else $error("vblank default wrong");

    chk_vsync_invert: assert property (
        o_timing.vsync == (i_raw.vsync ^
            polarity_reg[timing_polarity_pkg::POL_VSYNC]))
        else $error("vsync polarity wrong");

    chk_hblank_invert: assert property (
        o_timing.hblank == (i_raw.hblank ^
            polarity_reg[timing_polarity_pkg::POL_HBLANK]))
        else $error("hblank polarity wrong");

    chk_hblank_default: assert property (
        !polarity_reg[timing_polarity_pkg::POL_HBLANK] |->
        o_timing.hblank == i_raw.hblank)
        else $error("hblank default wrong");

    chk_hsync_default: assert property (
        !polarity_reg[timing_polarity_pkg::POL_HSYNC] |->
        o_timing.hsync == i_raw.hsync_n)
        else $error("hsync not active low");

    chk_stop_write: assert property (
        psel && penable && pwrite && hit_stop |=>
        pulse_stop_reg == 16'($past(pwdata)))
        else $error("stop register not updated");

    chk_pulse_start: assert property (
        i_raw.pixel_count < pulse_start_reg |-> !o_timing.custom_line_pulse)
        else $error("user pulse before start pixel");

    sequence s_start_read;
        psel && !penable && !pwrite && hit_start;
    endsequence

    chk_start_read: assert property (
        s_start_read |=> prdata == {16'h0000, $past(pulse_start_reg)})
        else $error("start register read wrong");

    chk_pol_write: assert property (
        s_pol_write |=> polarity_reg ==
        (16'($past(pwdata)) & timing_polarity_pkg::POL_WRITE_MASK))
        else $error("polarity register not updated");

endmodule

`default_nettype wire

// ---- dv/timing_raster_model.sv ----
// Small raster source feeding raw timing into the polarity block
`timescale 1ns/1ps
`default_nettype none
module timing_raster_model #(
    parameter int LINE_LEN = 16,
    parameter int LINES = 4
) (
    input wire logic i_clk_sys,
    output timing_polarity_pkg::raw_timing_t o_raw
);
    int pix = 0;
    int line = 0;
    int field = 0;
    int frame = 0;
    // Short raster keeps a ten-field sequence near 640 cycles
    always @(posedge i_clk_sys) begin
        if (pix == LINE_LEN - 1) begin
            pix <= 0;
            if (line == LINES - 1) begin
                line <= 0;
                field <= 1 - field;
                frame <= frame + field;
            end else begin
                line <= line + 1;
            end
        end else begin
            pix <= pix + 1;
        end
    end
    always_comb begin
        o_raw.hsync_n = !(pix < 2);
        o_raw.hblank = (pix < 4) || (pix >= LINE_LEN - 2);
        o_raw.vsync = (line == 0);
        o_raw.vblank = (line == 0) || (line == LINES - 1);
        o_raw.field_sync_one = (field == 0);
        o_raw.field_digital_one = (field == 0);
        o_raw.line_start = (pix == 0);
        o_raw.field_start = (pix == 0) && (line == 0);
        // divider reset at line one of every second frame
        o_raw.audio_div_reset = (pix == 0) && (line == 0) && (field == 0)
            && (frame % 2 == 0);
        o_raw.pixel_count = 16'(pix);
    end
endmodule
`default_nettype wire

// ---- dv/timing_output_polarity_bench.sv ----
// Self-checking bench for the timing output polarity block
`timescale 1ns/1ps
`default_nettype none
module timing_output_polarity_bench;
    logic i_clk_sys = 1'b0;
    logic i_srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    timing_polarity_pkg::raw_timing_t raw;
    timing_polarity_pkg::timing_out_t out, out_na;
    int err_total = 0;
    int check_count = 0;
    int m_pol = 0;
    int m_start = 0;
    int m_stop = 0;
    int m_cnt = 9;
    logic m_ten = 1'b0;
    logic m_aud = 1'b0;
    logic [31:0] seed = 32'h0000_9665;
    logic [31:0] rd;
    logic err;
    int bits[9] = '{0, 1, 2, 3, 4, 5, 7, 8, 9};
    always #2.5 i_clk_sys = ~i_clk_sys;
    timing_raster_model i_timing_raster_model (.i_clk_sys(i_clk_sys),
        .o_raw(raw));
    timing_output_polarity i_timing_output_polarity (.i_clk_sys(i_clk_sys),
        .i_srst(i_srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_raw(raw), .o_timing(out));
    // Variant without audio shares every input
    timing_output_polarity #(.HAS_AUDIO(1'b0)) i_timing_output_polarity_na (
        .i_clk_sys(i_clk_sys), .i_srst(i_srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(), .pready(), .pslverr(), .i_raw(raw), .o_timing(out_na));
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (e !== g) begin
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
            err_total++;
        end
    endtask
    task automatic apb(input bit wr, input logic [7:0] idx,
            input logic [15:0] wd);
        @(posedge i_clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {16'h0000, wd};
        @(posedge i_clk_sys);
        penable <= 1'b1;
        @(posedge i_clk_sys);
        while (pready !== 1'b1) @(posedge i_clk_sys);
        rd = prdata;
        err = pslverr;
        if (wr && err === 1'b0) begin
            case (idx)
                timing_polarity_pkg::IDX_POLARITY:
                    m_pol <= int'(wd & timing_polarity_pkg::POL_WRITE_MASK);
                timing_polarity_pkg::IDX_PULSE_START: m_start <= int'(wd);
                timing_polarity_pkg::IDX_PULSE_STOP: m_stop <= int'(wd);
                default: ;
            endcase
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] idx, input int e, input bit e_err);
        apb(1'b0, idx, 16'h0000);
        check(32'(e), rd);
        check({31'h0, e_err}, {31'h0, err});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Reference model of both markers, reset like the device
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            m_pol <= 0;
            m_start <= 0;
            m_stop <= 0;
            m_cnt <= 9;
            m_ten <= 1'b0;
            m_aud <= 1'b0;
        end else begin
            if (raw.line_start) begin
                m_ten <= 1'b0;
                m_aud <= 1'b0;
            end
            if (raw.field_start) begin
                m_cnt <= (m_cnt == 9) ? 0 : m_cnt + 1;
                if (m_cnt == 9) m_ten <= 1'b1;
            end
            if (raw.audio_div_reset) m_aud <= 1'b1;
        end
    end
    // Every timing output of the audio variant, the no-audio marker and pready compared each cycle, half a period after the edge
    always @(negedge i_clk_sys) begin
        if (!i_srst) begin
            check({28'h0, raw.hsync_n ^ m_pol[0], raw.hblank ^ m_pol[1],
                raw.vsync ^ m_pol[2], raw.vblank ^ m_pol[3]},
                {28'h0, out.hsync, out.hblank, out.vsync,
                out.vblank});
            check({29'h0, raw.field_sync_one ^ m_pol[4],
                raw.field_digital_one ^ m_pol[5],
                ~raw.hblank & ~raw.vblank ^ m_pol[7]},
                {29'h0, out.field_sync, out.field_digital,
                out.display_enable});
            check({30'h0, m_ten ^ m_pol[8], m_aud ^ m_pol[9]},
                {30'h0, out.ten_field_marker,
                out.audio_frame_marker});
            check({31'h0, m_start <= int'(raw.pixel_count)
                && int'(raw.pixel_count) < m_stop},
                {31'h0, out.custom_line_pulse});
            check(32'h0000_0000, {31'h0, out_na.audio_frame_marker});
            check(32'h0000_0001, {31'h0, pready});
        end
    end
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
    initial begin
        int s;
        repeat (20) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        rdchk(timing_polarity_pkg::IDX_POLARITY, 0, 1'b0);
        rdchk(timing_polarity_pkg::IDX_PULSE_START, 0, 1'b0);
        rdchk(timing_polarity_pkg::IDX_PULSE_STOP, 0, 1'b0);
        $display("reset values done");
        foreach (bits[i]) begin
            apb(1'b1, timing_polarity_pkg::IDX_POLARITY,
                16'(1 << bits[i]));
            repeat (700) @(posedge i_clk_sys);
            rdchk(timing_polarity_pkg::IDX_POLARITY,
                1 << bits[i], 1'b0);
        end
        $display("single bits done");
        repeat (8) begin
            // software keeps the reserved bit clear
            apb(1'b1, timing_polarity_pkg::IDX_POLARITY,
                16'(xorshift()) & 16'hFFBF);
            s = int'(xorshift() % 15);
            apb(1'b1, timing_polarity_pkg::IDX_PULSE_START, 16'(s));
            apb(1'b1, timing_polarity_pkg::IDX_PULSE_STOP,
                16'(s + 1 + int'(xorshift() % (15 - s))));
            repeat (300) @(posedge i_clk_sys);
            rdchk(timing_polarity_pkg::IDX_POLARITY, m_pol, 1'b0);
            rdchk(timing_polarity_pkg::IDX_PULSE_START, m_start, 1'b0);
            rdchk(timing_polarity_pkg::IDX_PULSE_STOP, m_stop, 1'b0);
        end
        $display("random values done");
        s = m_pol;
        rdchk(8'h59, 0, 1'b1);
        apb(1'b1, 8'h55, 16'hFFFF);
        check(32'h0000_0001, {31'h0, err});
        rdchk(timing_polarity_pkg::IDX_POLARITY, s, 1'b0);
        $display("unmapped done");
        i_srst <= 1'b1;
        repeat (20) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        rdchk(timing_polarity_pkg::IDX_POLARITY, 0, 1'b0);
        rdchk(timing_polarity_pkg::IDX_PULSE_START, 0, 1'b0);
        repeat (700) @(posedge i_clk_sys);
        $display("second reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
